// File: common/iepr_map.vh
// register offsets, field positions and reset values for the enable/priority block
`ifndef IEPR_MAP_VH
`define IEPR_MAP_VH
`define IEPR_ENABLE_ADDR      8'hA8
`define IEPR_PRIORITY_ADDR    8'hB8
`define IEPR_ENABLE_RESET     8'h00
`define IEPR_PRIORITY_RESET   8'h80
`define IEPR_PRIORITY_RO_MASK 8'h80
`define IEPR_GLOBAL_BIT       7
`define IEPR_SERIAL_BIT       6
`define IEPR_TIMER2_BIT       5
`define IEPR_ASYNC_BIT        4
`define IEPR_TIMER1_BIT       3
`define IEPR_EXT1_BIT         2
`define IEPR_TIMER0_BIT       1
`define IEPR_EXT0_BIT         0
`define IEPR_NUM_SRC          7
`define IEPR_IDX_W            3
`define IEPR_CALL_CYCLES      4
`define IEPR_DETECT_CYCLES    1
`endif

// File: hdl/iepr_pick.v
// fixed-order picker: lowest set index wins
`timescale 1ns/1ps
`include "iepr_map.vh"
module iepr_pick (
	// candidate requests
	input  wire [`IEPR_NUM_SRC-1:0] req_in,
	// winner
	output reg                      any_out,
	output reg  [`IEPR_IDX_W-1:0]   idx_out
);
	integer i;
	// scan from the top so the lowest index is written last
	always @* begin
		any_out = 1'b0;
		idx_out = {`IEPR_IDX_W{1'b0}};
		for (i = `IEPR_NUM_SRC-1; i >= 0; i = i - 1) begin
			if (req_in[i]) begin
				any_out = 1'b1;
				idx_out = i[`IEPR_IDX_W-1:0];
			end
		end
	end
endmodule // iepr_pick

// File: hdl/iepr_top.v
// interrupt enable and priority registers with masked, prioritised request outputs
// Notes on behaviour
// - global enable off blocks every source
// - serial peripheral mask gates its requests
// - timer2 mask gates either overflow flag
// - async port mask gates its interrupt
// - timer1 mask gates overflow requests
// - external line 1 mask gates requests
// - timer0 mask gates overflow requests
// - external line 0 mask gates requests
// - priority bit 6 sets serial peripheral level
// - priority bit 7 reads one, ignores writes
// - high preempts low; high never preempted
// - same level resolved by fixed source order
// - requests sampled and decoded every cycle
`timescale 1ns/1ps
`include "iepr_map.vh"
module iepr_top (
	// clock and reset
	input  wire                     clk_in,
	input  wire                     resetn_in,
	// special register access from the core
	input  wire [7:0]               sfr_addr_in,
	input  wire                     sfr_wr_in,
	input  wire [7:0]               sfr_wdata_in,
	output reg  [7:0]               sfr_rdata_out,
	// peripheral pending flags
	input  wire                     ext_line0_input_in,
	input  wire                     timer0_overflow_flag_in,
	input  wire                     ext_line1_input_in,
	input  wire                     timer1_overflow_flag_in,
	input  wire                     async_serial_unit_irq_in,
	input  wire                     timer2_low_overflow_flag_in,
	input  wire                     timer2_high_overflow_flag_in,
	input  wire                     serial_periph_unit_irq_in,
	// core service tracking
	input  wire                     vector_taken_in,
	input  wire                     service_return_in,
	// requests to vectoring logic
	output reg                      irq_req_out,
	output reg  [`IEPR_IDX_W-1:0]   irq_idx_out,
	output reg                      irq_high_out,
	output wire [`IEPR_NUM_SRC-1:0] masked_req_out,
	output wire [1:0]               active_level_out
);
	////////////////////////////////////////////////////////////////////////
	reg       rst_meta;
	reg       rst_sync;
	reg [7:0] interrupt_enable;
	reg [6:0] interrupt_priority_rw;
	reg       in_low;
	reg       in_high;
	wire [7:0] interrupt_priority;
	wire [`IEPR_NUM_SRC-1:0] raw_req;
	wire [`IEPR_NUM_SRC-1:0] en_req;
	wire [`IEPR_NUM_SRC-1:0] hi_req;
	wire [`IEPR_NUM_SRC-1:0] lo_req;
	wire                     hi_any;
	wire                     lo_any;
	wire [`IEPR_IDX_W-1:0]   hi_idx;
	wire [`IEPR_IDX_W-1:0]   lo_idx;
	reg                      next_req;
	reg  [`IEPR_IDX_W-1:0]   next_idx;
	reg                      next_high;

	// reset release through two flops; assert is asynchronous
	always @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			rst_meta <= 1'b0;
			rst_sync <= 1'b0;
		end else begin
			rst_meta <= 1'b1;
			rst_sync <= rst_meta;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// register writes; bit 7 of priority has no storage at all
	always @(posedge clk_in or negedge rst_sync) begin
		if (!rst_sync) begin
			interrupt_enable      <= `IEPR_ENABLE_RESET;
			interrupt_priority_rw <= 7'h00;
		end else if (sfr_wr_in) begin
			if (sfr_addr_in == `IEPR_ENABLE_ADDR)
				interrupt_enable <= sfr_wdata_in;
			if (sfr_addr_in == `IEPR_PRIORITY_ADDR)
				interrupt_priority_rw <= sfr_wdata_in[6:0];
		end
	end

	// top bit forced high on read
	assign interrupt_priority = {1'b1, interrupt_priority_rw};

	// read mux; unmapped addresses read zero
	always @* begin
		case (sfr_addr_in)
			`IEPR_ENABLE_ADDR:   sfr_rdata_out = interrupt_enable;
			`IEPR_PRIORITY_ADDR: sfr_rdata_out = interrupt_priority;
			default:             sfr_rdata_out = 8'h00;
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// source vector in fixed arbitration order, index 0 first
	assign raw_req[0] = ext_line0_input_in;
	assign raw_req[1] = timer0_overflow_flag_in;
	assign raw_req[2] = ext_line1_input_in;
	assign raw_req[3] = timer1_overflow_flag_in;
	assign raw_req[4] = async_serial_unit_irq_in;
	assign raw_req[5] = timer2_low_overflow_flag_in | timer2_high_overflow_flag_in;
	assign raw_req[6] = serial_periph_unit_irq_in;

	// enable bits line up with source index; global bit overrides all
	genvar g;
	generate
		for (g = 0; g < `IEPR_NUM_SRC; g = g + 1) begin : gen_mask
			assign en_req[g] = raw_req[g] & interrupt_enable[g]
				& interrupt_enable[`IEPR_GLOBAL_BIT];
			assign hi_req[g] = en_req[g] & interrupt_priority[g];
			assign lo_req[g] = en_req[g] & ~interrupt_priority[g];
		end
	endgenerate

	assign masked_req_out   = en_req;
	assign active_level_out = {in_high, in_low};

	iepr_pick u_pick_hi (
		.req_in  (hi_req),
		.any_out (hi_any),
		.idx_out (hi_idx)
	);

	iepr_pick u_pick_lo (
		.req_in  (lo_req),
		.any_out (lo_any),
		.idx_out (lo_idx)
	);

	////////////////////////////////////////////////////////////////////////
	// preemption: high beats idle/low service, low only when idle
	always @* begin
		next_req  = 1'b0;
		next_idx  = {`IEPR_IDX_W{1'b0}};
		next_high = 1'b0;
		if (hi_any && !in_high) begin
			next_req  = 1'b1;
			next_idx  = hi_idx;
			next_high = 1'b1;
		end else if (lo_any && !in_high && !in_low) begin
			next_req  = 1'b1;
			next_idx  = lo_idx;
		end
	end

	// one cycle of detect latency, refreshed every clock
	always @(posedge clk_in or negedge rst_sync) begin
		if (!rst_sync) begin
			irq_req_out  <= 1'b0;
			irq_idx_out  <= {`IEPR_IDX_W{1'b0}};
			irq_high_out <= 1'b0;
		end else begin
			irq_req_out  <= next_req;
			irq_idx_out  <= next_idx;
			irq_high_out <= next_high;
		end
	end

	// service level tracking; return unwinds the innermost level first
	always @(posedge clk_in or negedge rst_sync) begin
		if (!rst_sync) begin
			in_low  <= 1'b0;
			in_high <= 1'b0;
		end else if (vector_taken_in && irq_req_out) begin
			if (irq_high_out)
				in_high <= 1'b1;
			else
				in_low <= 1'b1;
		end else if (service_return_in) begin
			if (in_high)
				in_high <= 1'b0;
			else
				in_low <= 1'b0;
		end
	end
endmodule // iepr_top

// File: verification/iepr_core_model.sv
// core model: vectors to a pending request after a set lag
`timescale 1ns/1ps
module iepr_core_model (
	input wire       clk_in,
	input wire       go_in,
	input wire [3:0] lag_in,
	input wire       irq_req_in,
	output reg       vector_taken_out
);
	reg [3:0] n = 4'h0;
	initial vector_taken_out = 1'b0;
	// one take per unbroken request in a go window; counter saturates at 15, so a lag of 15 fires every cycle once reached
	always @(posedge clk_in) begin
		vector_taken_out <= go_in && irq_req_in && n == lag_in;
		n <= (go_in && irq_req_in) ? n + {3'h0, n != 4'hF} : 4'h0;
	end
endmodule // iepr_core_model

// File: verification/iepr_chk_sva.sv
// port assertions for the enable/priority block
`timescale 1ns/1ps
module iepr_chk (
	input wire       clk_in,
	input wire       resetn_in,
	input wire [7:0] sfr_addr_in,
	input wire       sfr_wr_in,
	input wire [7:0] sfr_wdata_in,
	input wire [7:0] sfr_rdata_out,
	input wire       vector_taken_in,
	input wire       irq_req_out,
	input wire [2:0] irq_idx_out,
	input wire       irq_high_out,
	input wire [6:0] masked_req_out,
	input wire [1:0] active_level_out
);
	default clocking @(posedge clk_in); endclocking
	default disable iff (!resetn_in);
	sequence s_en_wr; sfr_wr_in && sfr_addr_in == 8'hA8; endsequence
	sequence s_take_lo; vector_taken_in && irq_req_out && !irq_high_out; endsequence
	sequence s_take_hi; vector_taken_in && irq_req_out && irq_high_out; endsequence
	a_unused_bit: assert property (sfr_addr_in == 8'hB8 |-> sfr_rdata_out[7])
		else $error("b7");
	a_enable_wr: assert property (s_en_wr ##1 sfr_addr_in == 8'hA8
		|-> sfr_rdata_out == $past(sfr_wdata_in)) else $error("en");
	a_idle_quiet: assert property (masked_req_out == 7'h00 |=> !irq_req_out) else $error("iq");
	a_req_raised: assert property (masked_req_out != 7'h00 && active_level_out == 2'h0
		|=> irq_req_out) else $error("rq");
	a_idx_valid: assert property (irq_req_out
		|-> (($past(masked_req_out) >> irq_idx_out) & 7'h01) != 7'h00) else $error("ix");
	a_high_hold: assert property (active_level_out[1] |=> !irq_req_out) else $error("hh");
	a_low_hold: assert property (irq_req_out && $past(active_level_out) != 2'h0
		|-> irq_high_out) else $error("lh");
	a_take_low: assert property (s_take_lo |=> active_level_out[0])
		else $error("low take did not enter low service");
	a_take_high: assert property (s_take_hi |=> active_level_out[1])
		else $error("high take did not enter high service");
endmodule // iepr_chk
bind iepr_top iepr_chk u_chk (.clk_in, .resetn_in, .sfr_addr_in, .sfr_wr_in, .sfr_wdata_in,
	.sfr_rdata_out, .vector_taken_in, .irq_req_out, .irq_idx_out, .irq_high_out,
	.masked_req_out, .active_level_out);

// File: verification/irq_enable_priority_regs_tb.sv
// self-checking bench for the enable/priority block
`timescale 1ns/1ps
module irq_enable_priority_regs_tb;
	reg clk = 1'b0, resetn = 1'b0, wr = 1'b0, go = 1'b0, ret = 1'b0;
	reg [7:0] addr = 8'h00, wd = 8'h00, f = 8'h00;
	reg [3:0] lag = 4'h0;
	wire [7:0] rd;
	wire vt, req, hi;
	wire [2:0] idx;
	wire [6:0] mreq;
	wire [1:0] lvl;
	integer errors = 0, n_compared = 0, i;
	iepr_top dut (.clk_in(clk), .resetn_in(resetn), .sfr_addr_in(addr), .sfr_wr_in(wr),
		.sfr_wdata_in(wd), .sfr_rdata_out(rd), .ext_line0_input_in(f[0]),
		.timer0_overflow_flag_in(f[1]), .ext_line1_input_in(f[2]),
		.timer1_overflow_flag_in(f[3]), .async_serial_unit_irq_in(f[4]),
		.timer2_low_overflow_flag_in(f[5]), .timer2_high_overflow_flag_in(f[7]),
		.serial_periph_unit_irq_in(f[6]), .vector_taken_in(vt), .service_return_in(ret),
		.irq_req_out(req), .irq_idx_out(idx), .irq_high_out(hi), .masked_req_out(mreq),
		.active_level_out(lvl));
	iepr_core_model core (.clk_in(clk), .go_in(go), .lag_in(lag), .irq_req_in(req),
		.vector_taken_out(vt));
	initial forever #50 clk = ~clk;
	task cy(input integer k); repeat (k) @(negedge clk); endtask
	task chk(input [7:0] s, input [7:0] e); begin
		n_compared = n_compared + 1;
		if (s !== e) begin
			errors = errors + 1;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
		end
	end endtask
	// write strobe held for exactly one rising edge
	task wrr(input [7:0] a, input [7:0] d); begin
		addr = a;
		wd = d;
		wr = 1'b1;
		cy(1);
		wr = 1'b0;
	end endtask
	task complete_run; begin
		$display("compared %0d mismatches %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	end endtask
	task t_regs; begin
		addr = 8'hA8;
		#1 chk(rd, 8'h00);
		wrr(8'hB8, 8'h00);
		chk(rd, 8'h80);
		wrr(8'hB8, 8'h7F);
		chk(rd, 8'hFF);
		$display("register test done");
	end endtask
	task t_masks; begin
		f = 8'hFF;
		for (i = 0; i < 7; i = i + 1) begin
			wrr(8'hA8, 8'h80 | (8'h01 << i));
			chk({1'b0, mreq}, 8'h01 << i);
		end
		wrr(8'hA8, 8'h7F);
		chk({1'b0, mreq}, 8'h00);
		f = 8'h80;
		wrr(8'hA8, 8'hA0);
		chk({1'b0, mreq}, 8'h20);
		$display("mask test done");
	end endtask
	// low service preempted by a high source, then one return unwinds the high level
	task t_preempt; begin
		f = 8'h09;
		wrr(8'hA8, 8'hFF);
		wrr(8'hB8, 8'h08);
		cy(1);
		chk({4'h0, hi, idx}, 8'h0B);
		wrr(8'hB8, 8'h00);
		cy(1);
		chk({4'h0, hi, idx}, 8'h00);
		lag = 4'h3;
		go = 1'b1;
		cy(6);
		go = 1'b0;
		wrr(8'hB8, 8'h08);
		cy(1);
		chk({3'h0, req, hi, idx}, 8'h1B);
		lag = 4'h0;
		go = 1'b1;
		cy(3);
		go = 1'b0;
		chk({5'h00, lvl, req}, 8'h06);
		ret = 1'b1;
		cy(1);
		ret = 1'b0;
		chk({6'h00, lvl}, 8'h01);
		$display("preempt test done");
	end endtask
	initial begin
		#50000;
		errors = errors + 1;
		complete_run;
	end
	initial begin
		cy(2);
		resetn = 1'b1;
		cy(3);
		t_regs;
		t_masks;
		t_preempt;
		complete_run;
	end
endmodule // irq_enable_priority_regs_tb
